// file: counter_status_flags_test.sv
`timescale 1ns/100ps
module counter_status_flags_test;
  // ==========================================
  // Signals
  // ==========================================
  localparam logic [31:0] BASE = 32'h00000055; // Idle count, hits nothing
  logic        clk_in;
  logic        rst_in;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [31:0] count;
  logic        step, dir_dn, ovf, unf, igate, hgate, olvl, latch;
  logic [15:0] status;
  logic        sw_gate;
  logic        irq;
  logic [31:0] rd_val;
  int          n_mismatch;
  int          n_checks;

  // ==========================================
  // Clock, design and host
  // ==========================================
  always #12.5 clk_in = ~clk_in;

  csf_status #(.CNT_W(32)) csf_status_i (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .count_in(count),
    .count_step_in(step), .count_dir_dn_in(dir_dn), .overflow_in(ovf),
    .underflow_in(unf), .int_gate_in(igate), .hw_gate_in(hgate),
    .out_level_in(olvl), .latch_in(latch), .status_out(status),
    .sw_gate_out(sw_gate), .irq_out(irq));

  csf_host_model csf_host_model_i (
    .clk_in(clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd), .rdata_in(rdata));

  // ==========================================
  // Helpers
  // ==========================================
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Let n edges land, then look between edges
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  // Level part of the status word from the current inputs
  function automatic logic [15:0] exp_lvl(input logic sw);
    logic [15:0] e;
    e = 16'h0000;
    e[csf_pkg::BIT_SW_GATE] = sw;
    e[csf_pkg::BIT_HW_GATE] = hgate;
    e[csf_pkg::BIT_I_GATE]  = igate;
    e[csf_pkg::BIT_OUT_LVL] = olvl;
    e[csf_pkg::BIT_CNT_DN]  = dir_dn;
    e[csf_pkg::BIT_CNT_UP]  = ~dir_dn;
    e[csf_pkg::BIT_LATCH]   = latch;
    return e;
  endfunction

  // Provoke event e (status order: compare, end, over, under, zero)
  task automatic fire(input int e);
    @(posedge clk_in);
    case (e)
      0: count <= 32'h00000100;
      1: count <= 32'h00000200;
      2: ovf <= 1'b1;
      3: unf <= 1'b1;
      default: count <= 32'h00000000;
    endcase
    @(posedge clk_in);
    ovf   <= 1'b0;
    unf   <= 1'b0;
    count <= BASE;
  endtask

  // Bounded wait for a sticky flag; a hang ends the run
  task automatic wait_flag(input int b);
    int k;
    k = 0;
    while (status[b] !== 1'b1 && k < 6)
    begin
      @(negedge clk_in);
      k++;
    end
    if (status[b] !== 1'b1)
    begin
      n_mismatch++;
      $display("unexpected at %0t: flag %0d never set", $time, b);
      wrap_up();
    end
  endtask

  // ==========================================
  // Main sequence
  // ==========================================
  initial
  begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    count  = BASE;
    {step, dir_dn, ovf, unf, igate, hgate, olvl, latch} = 8'h00;
    n_mismatch = 0;
    n_checks = 0;
    void'($urandom(31));
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    settle(2);
    check(status, exp_lvl(1'b0), "status after reset");
    // Random levels on every mirrored input
    for (int i = 0; i < 24; i++)
    begin
      @(posedge clk_in);
      {dir_dn, igate, hgate, olvl, latch, step} <= 6'($urandom());
      settle(1);
      check(status, exp_lvl(1'b0), "level bits");
    end
    // Gate on, compare on, limits, mask, then clear stale flags
    csf_host_model_i.bus_write(csf_pkg::OFS_CTRL, 32'h00000003, 0);
    csf_host_model_i.bus_write(csf_pkg::OFS_CMPVAL, 32'h00000100, 0);
    csf_host_model_i.bus_write(csf_pkg::OFS_ENDVAL, 32'h00000200, 2);
    csf_host_model_i.bus_write(csf_pkg::OFS_IRQ_MASK, 32'h00003E00, 0);
    csf_host_model_i.bus_write(csf_pkg::OFS_STATUS, 32'h00003E00, 0);
    settle(2);
    check(sw_gate, 1'b1, "software gate out");
    check(status, exp_lvl(1'b1), "gate bit, flags clear");
    check(irq, 1'b0, "irq idle");
    // Each event: set, stays set, visible on the bus, cleared by a one
    for (int e = 0; e < 5; e++)
    begin
      fire(e);
      wait_flag(csf_pkg::EVT_LSB + e);
      settle(3);
      check(status, exp_lvl(1'b1) | (16'h0200 << e), "event flag");
      check(irq, 1'b1, "irq on event");
      csf_host_model_i.bus_read(csf_pkg::OFS_STATUS, 0, rd_val);
      check(rd_val, {16'h0000, exp_lvl(1'b1) | (16'h0200 << e)}, "status read");
      csf_host_model_i.bus_write(csf_pkg::OFS_STATUS, 32'h00000200 << e, 0);
      settle(1);
      check(status, exp_lvl(1'b1), "flag cleared");
      check(irq, 1'b0, "irq cleared");
    end
    // Masked overflow: flag still set, no interrupt
    csf_host_model_i.bus_write(csf_pkg::OFS_IRQ_MASK, 32'h00000000, 0);
    fire(2);
    wait_flag(csf_pkg::BIT_OFLW);
    settle(1);
    check(irq, 1'b0, "masked irq");
    csf_host_model_i.bus_write(csf_pkg::OFS_STATUS, 32'h00000800, 0);
    // Compare switched off: a match must leave bit 9 alone
    csf_host_model_i.bus_write(csf_pkg::OFS_CTRL, 32'h00000001, 0);
    fire(0);
    settle(3);
    check(status, exp_lvl(1'b1), "compare disabled");
    // Unmapped place: write ignored, read gives zero
    csf_host_model_i.bus_write(4'hF, $urandom(), 0);
    csf_host_model_i.bus_read(4'hF, 0, rd_val);
    check(rd_val, 32'h00000000, "unmapped read");
    // Read back every mapped register but status, and the live count
    csf_host_model_i.bus_read(csf_pkg::OFS_CTRL, 0, rd_val);
    check(rd_val, 32'h00000001, "ctrl read");
    csf_host_model_i.bus_read(csf_pkg::OFS_CMPVAL, 0, rd_val);
    check(rd_val, 32'h00000100, "compare value read");
    csf_host_model_i.bus_read(csf_pkg::OFS_ENDVAL, 0, rd_val);
    check(rd_val, 32'h00000200, "end value read");
    csf_host_model_i.bus_read(csf_pkg::OFS_IRQ_MASK, 0, rd_val);
    check(rd_val, 32'h00000000, "mask read");
    csf_host_model_i.bus_read(csf_pkg::OFS_COUNT, 0, rd_val);
    check(rd_val, BASE, "count read");
    wrap_up();
  end
endmodule

// file: csf_event_flag.sv
`timescale 1ns/100ps
// ============================================================
// Sticky event flags: set by hardware, cleared by writing one
// ============================================================
module csf_event_flag #(
  parameter int unsigned WIDTH = 5
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Event pulses and write-one clear
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  // Flag state
  output logic      [WIDTH-1:0] flag_out
);
  initial
  begin
    if (WIDTH < 1)
      $error("csf_event_flag: WIDTH must be at least 1");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_flag
      // Set wins over clear so an event in the clearing cycle is kept
      always_ff @(posedge clk_in or posedge rst_in)
      begin
        if (rst_in)
          flag_out[i] <= 1'b0;
        else if (set_in[i])
          flag_out[i] <= 1'b1; // [R12]
        else if (clr_in[i])
          flag_out[i] <= 1'b0;
      end
    end
  endgenerate
endmodule

// file: csf_host_model.sv
`timescale 1ns/100ps
// ======================================================
// Controlling program: master on the plain register port
// ======================================================
module csf_host_model (
  // Clock
  input  wire logic        clk_in,
  // Register port
  output logic      [3:0]  addr_out,
  output logic      [31:0] wdata_out,
  output logic             wr_out,
  output logic             rd_out,
  input  wire logic [31:0] rdata_in
);
  // Idle bus, strobes low
  initial
  begin
    addr_out  = 4'h0;
    wdata_out = 32'h00000000;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // One-cycle write; gap idles first to act as a slow host
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d, input int gap);
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    // Released lines show junk, so stale values never look valid
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask

  // One-cycle read; data taken in the cycle after the strobe only
  task automatic bus_read(input logic [3:0] a, input int gap, output logic [31:0] d);
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    @(negedge clk_in);
    d = rdata_in;
  endtask
endmodule

// file: csf_pkg.sv
package csf_pkg;
  // ==========================================================
  // Status word bit positions
  // ==========================================================
  localparam int unsigned STAT_W       = 16;
  localparam int unsigned BIT_SW_GATE  = 2;
  localparam int unsigned BIT_HW_GATE  = 4;
  localparam int unsigned BIT_I_GATE   = 5;
  localparam int unsigned BIT_OUT_LVL  = 6;
  localparam int unsigned BIT_CNT_DN   = 7;
  localparam int unsigned BIT_CNT_UP   = 8;
  localparam int unsigned BIT_CMP      = 9;
  localparam int unsigned BIT_END      = 10;
  localparam int unsigned BIT_OFLW     = 11;
  localparam int unsigned BIT_UFLW     = 12;
  localparam int unsigned BIT_ZERO     = 13;
  localparam int unsigned BIT_LATCH    = 14;
  // Sticky event flags, in status order from bit 9 upward
  localparam int unsigned NUM_EVT      = 5;
  localparam int unsigned EVT_LSB      = 9;
  // ==========================================================
  // Register offsets (word addresses on the plain port)
  // ==========================================================
  localparam int unsigned ADDR_W       = 4;
  localparam logic [3:0]  OFS_STATUS   = 4'h0;
  localparam logic [3:0]  OFS_CTRL     = 4'h1;
  localparam logic [3:0]  OFS_CMPVAL   = 4'h2;
  localparam logic [3:0]  OFS_ENDVAL   = 4'h3;
  localparam logic [3:0]  OFS_IRQ_MASK = 4'h4;
  localparam logic [3:0]  OFS_COUNT    = 4'h5;
  // Control register: bit 0 software gate, bit 1 compare enable
  localparam int unsigned CTRL_SW_GATE = 0;
  localparam int unsigned CTRL_CMP_EN  = 1;
  localparam logic [1:0]  CTRL_RST     = 2'h0;
  // Compare unit state
  typedef enum logic [1:0]
  {
    CSF_CMP_IDLE  = 2'b01,
    CSF_CMP_ARMED = 2'b10
  } csf_cmp_state_t;
endpackage

// file: csf_status.sv
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
// Notes on behaviour
// R01: Bit 7 set while counting backward
// R02: Bit 8 set while counting forward
// R03: Bit 9 on compare match, never if disabled
// R04: Bit 10 set when count equals end
// R05: Bit 11 overflow, bit 12 underflow
// R06: Bit 13 set on zero crossing
// R07: Bit 14 shows latch input level
// R08: Bit 6 mirrors digital output level
// R09: Bit 5 shows internal gate open
// R10: Bit 4 shows hardware gate input
// R11: Bit 2 shows software gate state
// R12: Event flags stay set until cleared
// R13: Up and down never both set
module csf_status #(
  parameter int unsigned CNT_W = 32
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Register port
  input  wire logic [3:0]       addr_in,
  input  wire logic [31:0]      wdata_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  output logic      [31:0]      rdata_out,
  // Counter engine observations
  input  wire logic [CNT_W-1:0] count_in,
  input  wire logic             count_step_in,
  input  wire logic             count_dir_dn_in,
  input  wire logic             overflow_in,
  input  wire logic             underflow_in,
  input  wire logic             int_gate_in,
  input  wire logic             hw_gate_in,
  input  wire logic             out_level_in,
  input  wire logic             latch_in,
  // Status and control outputs
  output logic      [15:0]      status_out,
  output logic                  sw_gate_out,
  output logic                  irq_out
);
  // ==========================================================
  // Elaboration checks
  // ==========================================================
  initial
  begin
    if (CNT_W < 2 || CNT_W > 32)
      $error("csf_status: CNT_W must lie in 2..32");
  end

  // ==========================================================
  // Control registers, previous count and compare state
  // ==========================================================
  logic [1:0]                      ctrl_reg;      // Gate and compare enable
  logic [CNT_W-1:0]                cmp_val_reg;   // Comparison value
  logic [CNT_W-1:0]                end_val_reg;   // End value
  logic [csf_pkg::NUM_EVT-1:0]     irq_mask_reg;  // Interrupt enables
  logic [CNT_W-1:0]                prev_cnt_reg;  // Count one cycle ago
  csf_pkg::csf_cmp_state_t         cmp_state_reg; // Compare edge state
  csf_pkg::csf_cmp_state_t         cmp_state_next;

  logic wr_ctrl;
  logic wr_stat;
  assign wr_ctrl = wr_in && (addr_in == csf_pkg::OFS_CTRL);
  assign wr_stat = wr_in && (addr_in == csf_pkg::OFS_STATUS);

  // Control word: software gate and compare enable
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      ctrl_reg <= csf_pkg::CTRL_RST;
    else if (wr_ctrl)
      ctrl_reg <= wdata_in[1:0];
  end

  // Comparison and end values
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cmp_val_reg <= '0;
      end_val_reg <= '0;
    end
    else if (wr_in)
    begin
      if (addr_in == csf_pkg::OFS_CMPVAL)
        cmp_val_reg <= wdata_in[CNT_W-1:0];
      if (addr_in == csf_pkg::OFS_ENDVAL)
        end_val_reg <= wdata_in[CNT_W-1:0];
    end
  end

  // Interrupt mask, same layout as the event flags
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_mask_reg <= '0;
    else if (wr_in && (addr_in == csf_pkg::OFS_IRQ_MASK))
      irq_mask_reg <= wdata_in[csf_pkg::EVT_LSB +: csf_pkg::NUM_EVT];
  end

  // ==========================================================
  // Event detection
  // ==========================================================
  // Previous count kept so zero crossing is seen only when the count changes to zero
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prev_cnt_reg <= '0;
    end
    else
    begin
      prev_cnt_reg <= count_in;
    end
  end

  logic cmp_match;
  logic end_hit;
  logic zero_hit;
  logic cmp_hit;
  assign cmp_match = (count_in == cmp_val_reg);
  // End flag fires when the count becomes equal, not while it stays
  assign end_hit   = (count_in == end_val_reg) && (prev_cnt_reg != end_val_reg); // [R04]
  // Zero crossing: count arrives at zero from a different value
  assign zero_hit  = (count_in == '0) && (prev_cnt_reg != '0); // [R06]

  // Compare unit: one event per entry into the match, none if disabled
  always_comb
  begin
    cmp_state_next = cmp_state_reg;
    cmp_hit        = 1'b0;
    case (cmp_state_reg)
      csf_pkg::CSF_CMP_IDLE:
      begin
        if (ctrl_reg[csf_pkg::CTRL_CMP_EN] && cmp_match)
        begin
          cmp_hit        = 1'b1; // [R03]
          cmp_state_next = csf_pkg::CSF_CMP_ARMED;
        end
      end
      csf_pkg::CSF_CMP_ARMED:
      begin
        // Wait for the count to leave the value, or compare to be disabled, before rearming
        if (!cmp_match || !ctrl_reg[csf_pkg::CTRL_CMP_EN])
          cmp_state_next = csf_pkg::CSF_CMP_IDLE;
      end
      default:
        cmp_state_next = csf_pkg::CSF_CMP_IDLE;
    endcase
  end

  // Compare state register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      cmp_state_reg <= csf_pkg::CSF_CMP_IDLE;
    else
      cmp_state_reg <= cmp_state_next;
  end

  // ==========================================================
  // Sticky event flags
  // ==========================================================
  logic [csf_pkg::NUM_EVT-1:0] evt_set;
  logic [csf_pkg::NUM_EVT-1:0] evt_flag;
  assign evt_set = {zero_hit, underflow_in, overflow_in, end_hit, cmp_hit}; // [R05]

  csf_event_flag #(
    .WIDTH (csf_pkg::NUM_EVT)
  ) u_flags (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .set_in   (evt_set),
    .clr_in   (wr_stat ? wdata_in[csf_pkg::EVT_LSB +: csf_pkg::NUM_EVT]
                       : {csf_pkg::NUM_EVT{1'b0}}),
    .flag_out (evt_flag)
  );

  // ==========================================================
  // Status word, software gate drive and interrupt
  // ==========================================================
  logic [15:0] status_next;
  always_comb
  begin
    status_next                       = '0;
    status_next[csf_pkg::BIT_SW_GATE] = ctrl_reg[csf_pkg::CTRL_SW_GATE]; // [R11]
    status_next[csf_pkg::BIT_HW_GATE] = hw_gate_in;                      // [R10]
    status_next[csf_pkg::BIT_I_GATE]  = int_gate_in;                     // [R09]
    status_next[csf_pkg::BIT_OUT_LVL] = out_level_in;                    // [R08]
    // Direction bits derive from one signal, so never both set
    status_next[csf_pkg::BIT_CNT_DN]  = count_dir_dn_in;                 // [R01] [R13]
    status_next[csf_pkg::BIT_CNT_UP]  = !count_dir_dn_in;                // [R02] [R13]
    status_next[csf_pkg::EVT_LSB +: csf_pkg::NUM_EVT] = evt_flag;        // [R12]
    status_next[csf_pkg::BIT_LATCH]   = latch_in;                        // [R07]
  end

  // Registered status word, one cycle behind its inputs
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      status_out <= '0;
    else
      status_out <= status_next;
  end

  // Software gate drive to the counter engine
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      sw_gate_out <= 1'b0;
    else
      sw_gate_out <= ctrl_reg[csf_pkg::CTRL_SW_GATE];
  end

  // Level interrupt from unmasked sticky flags
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(evt_flag & irq_mask_reg);
  end

  // ==========================================================
  // Read data, one cycle after the strobe
  // ==========================================================
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_out <= '0;
    else if (rd_in)
    begin
      case (addr_in)
        csf_pkg::OFS_STATUS:   rdata_out <= {16'h0000, status_next};
        csf_pkg::OFS_CTRL:     rdata_out <= {30'h00000000, ctrl_reg};
        csf_pkg::OFS_CMPVAL:   rdata_out <= 32'(cmp_val_reg);
        csf_pkg::OFS_ENDVAL:   rdata_out <= 32'(end_val_reg);
        csf_pkg::OFS_IRQ_MASK: rdata_out <= 32'(irq_mask_reg) << csf_pkg::EVT_LSB;
        csf_pkg::OFS_COUNT:    rdata_out <= 32'(count_in);
        default:               rdata_out <= '0;
      endcase
    end
    else
      rdata_out <= '0;
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  dir_exclusive_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R13]
    !(status_out[csf_pkg::BIT_CNT_DN] && status_out[csf_pkg::BIT_CNT_UP]))
    else $error("direction flags both set");

  dir_down_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R01]
    count_dir_dn_in |=> status_out[csf_pkg::BIT_CNT_DN])
    else $error("down flag missing");

  dir_up_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R02]
    !count_dir_dn_in |=> status_out[csf_pkg::BIT_CNT_UP])
    else $error("up flag missing");

  cmp_never_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R03]
    !ctrl_reg[csf_pkg::CTRL_CMP_EN] && !evt_flag[csf_pkg::BIT_CMP - csf_pkg::EVT_LSB]
    |=> !evt_flag[csf_pkg::BIT_CMP - csf_pkg::EVT_LSB])
    else $error("compare hit while disabled");

  sequence end_reach_s;
    (count_in == end_val_reg) && (prev_cnt_reg != end_val_reg);
  endsequence
  end_flag_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R04]
    end_reach_s |=> ##1 status_out[csf_pkg::BIT_END])
    else $error("end flag not set");

  ovf_flag_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R05]
    overflow_in |=> ##1 status_out[csf_pkg::BIT_OFLW])
    else $error("overflow flag not set");

  unf_flag_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R05]
    underflow_in |=> ##1 status_out[csf_pkg::BIT_UFLW])
    else $error("underflow flag not set");

  zero_flag_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R06]
    (count_in == '0) && (prev_cnt_reg != '0) |=> ##1 status_out[csf_pkg::BIT_ZERO])
    else $error("zero crossing flag not set");

  level_mirror_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R07] [R08]
    ##1 (status_out[csf_pkg::BIT_LATCH] == $past(latch_in))
    && (status_out[csf_pkg::BIT_OUT_LVL] == $past(out_level_in)))
    else $error("latch or output level not mirrored");

  gate_mirror_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R09]
    ##1 (status_out[csf_pkg::BIT_I_GATE] == $past(int_gate_in))
    && (status_out[csf_pkg::BIT_HW_GATE] == $past(hw_gate_in)))
    else $error("gate state not mirrored");

  sticky_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R12]
    // Status lags the flag by one edge, so a clear shows up one cycle late
    status_out[csf_pkg::BIT_OFLW] && !$past(wr_stat) |=> status_out[csf_pkg::BIT_OFLW])
    else $error("overflow flag dropped without clear");

  sw_gate_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R11]
    wr_ctrl |=> ##1 status_out[csf_pkg::BIT_SW_GATE] == $past(wdata_in[0], 2))
    else $error("software gate bit wrong");
endmodule
